// ===== ssd_top.sv
// Serial peripheral: status flags, data buffer and master baud select.
// Assumes synchronous pins and a master that never waits on reads.
//
// Functional notes
// R1: Master clock divides by 4 to 128.
// R2: Transfer done sets flag, irq if enabled.
// R3: Done flag clears: status access, data access.
// R4: Data writes ignored while done flag set.
// R5: Data write while shifting sets collision.
// R6: Slave select low in master sets fault.
// R7: Fault clears: status access, then control write.
// R8: Only data write starts master transfer.
// R9: Received byte copied to buffer; reads return it.
// R10: Data write loads shift register directly.
// R11: Status read-only, resets zero, unused read 0.
// R12: Fault clears output enable and master bits.
// R13: Collision flag never raises an interrupt.
// R14: Collision clears: status read, data read.
`timescale 1ns/10ps
`default_nettype none
module ssd_top
  import ssd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  input wire logic i_ss_n,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic done_reg;
  logic write_collision_flag_reg;
  logic mode_fault_flag_reg;
  logic done_arm_reg;
  logic write_collision_flag_arm_reg;
  logic mode_fault_flag_arm_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] rx_buf_reg;
  logic [7:0] shift_reg;
  logic capt_reg;
  logic dout_reg;
  logic [3:0] edge_cnt_reg;
  logic sck_lvl_reg;
  logic sck_prev_reg;
  ssd_state_t state_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_data, rd_data, wr_ctrl, acc_stat, rd_stat;
  logic master, slave_sel, busy, wr_load, start;
  logic fault_set, done_set, write_collision_flag_set;
  logic tick, slv_edge, edge_ev, lead, sample_in, last_edge;
  logic cpol, cpha;
  logic [2:0] rate_code;

  assign wr_data = i_wr && (i_addr == SSD_OFF_DATA);
  assign rd_data = i_rd && (i_addr == SSD_OFF_DATA);
  assign wr_ctrl = i_wr && (i_addr == SSD_OFF_CTRL);
  assign acc_stat = (i_wr || i_rd) && (i_addr == SSD_OFF_STAT);
  assign rd_stat = i_rd && (i_addr == SSD_OFF_STAT);
  assign master = ctrl_reg[SSD_CR_MASTER];
  assign cpol = ctrl_reg[SSD_CR_CPOL];
  assign cpha = ctrl_reg[SSD_CR_CPHA];
  assign rate_code = {ctrl_reg[SSD_CR_RATE_HI], ctrl_reg[SSD_CR_RATE_MID],
                      ctrl_reg[SSD_CR_RATE_LO]};
  assign slave_sel = ctrl_reg[SSD_CR_OUT_EN] && !master && !i_ss_n;
  assign busy = (state_reg == SSD_SHIFT) || slave_sel;
  assign fault_set = master && !i_ss_n; // see R6
  assign wr_load = wr_data && !done_reg && !busy; // see R4
  assign write_collision_flag_set = wr_data && busy; // see R5
  assign start = wr_load && master && ctrl_reg[SSD_CR_OUT_EN] && !fault_set; // see R8

  // ----------------------------------------------------------------
  // Edge sources
  // ----------------------------------------------------------------
  ssd_rate_gen #(
    .HALF_W(SSD_HALF_W)
  ) u_rate (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_run(state_reg == SSD_SHIFT),
    .i_code(rate_code),
    .o_tick(tick)
  );

  assign slv_edge = slave_sel && (i_sck != sck_prev_reg);
  assign edge_ev = (state_reg == SSD_SHIFT) ? tick : slv_edge;
  assign lead = !edge_cnt_reg[0];
  assign sample_in = master ? i_miso : i_mosi;
  assign last_edge = edge_ev && (edge_cnt_reg == SSD_LAST_EDGE);
  assign done_set = last_edge;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_reg <= SSD_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= i_wdata;
        if (mode_fault_flag_reg && !mode_fault_flag_arm_reg) begin
          ctrl_reg[SSD_CR_OUT_EN] <= i_wdata[SSD_CR_OUT_EN] && ctrl_reg[SSD_CR_OUT_EN];
          ctrl_reg[SSD_CR_MASTER] <= i_wdata[SSD_CR_MASTER] && ctrl_reg[SSD_CR_MASTER];
        end
      end
      if (fault_set) begin
        ctrl_reg[SSD_CR_OUT_EN] <= 1'b0; // see R12
        ctrl_reg[SSD_CR_MASTER] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and clearing sequences
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      done_reg <= SSD_STAT_RST[SSD_SR_DONE]; // see R11
      done_arm_reg <= 1'b0;
    end else begin
      if (done_set) begin
        done_reg <= 1'b1; // see R2
      end else if (done_arm_reg && (wr_data || rd_data)) begin
        done_reg <= 1'b0; // see R3
      end
      if (done_set || !done_reg || (wr_data || rd_data)) begin
        done_arm_reg <= 1'b0;
      end else if (acc_stat) begin
        done_arm_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      write_collision_flag_reg <= SSD_STAT_RST[SSD_SR_WRITE_COLLISION_FLAG];
      write_collision_flag_arm_reg <= 1'b0;
    end else begin
      if (write_collision_flag_set) begin
        write_collision_flag_reg <= 1'b1;
      end else if (write_collision_flag_arm_reg && rd_data) begin
        write_collision_flag_reg <= 1'b0; // see R14
      end
      if (write_collision_flag_set || !write_collision_flag_reg || rd_data) begin
        write_collision_flag_arm_reg <= 1'b0;
      end else if (rd_stat) begin
        write_collision_flag_arm_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mode_fault_flag_reg <= SSD_STAT_RST[SSD_SR_MODE_FAULT_FLAG];
      mode_fault_flag_arm_reg <= 1'b0;
    end else begin
      if (fault_set) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (mode_fault_flag_arm_reg && wr_ctrl) begin
        mode_fault_flag_reg <= 1'b0; // see R7
      end
      if (fault_set || !mode_fault_flag_reg || wr_ctrl) begin
        mode_fault_flag_arm_reg <= 1'b0;
      end else if (acc_stat) begin
        mode_fault_flag_arm_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_stat_reg <= SSD_IRQ_RST;
      irq_mask_reg <= SSD_IRQ_RST;
      o_irq <= 1'b0;
    end else begin
      if (i_wr && i_addr == SSD_OFF_IRQ_MASK) begin
        irq_mask_reg <= i_wdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (i_wr && i_addr == SSD_OFF_IRQ_STAT && i_wdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (done_set) begin
        irq_stat_reg[SSD_IRQ_DONE] <= 1'b1;
      end
      if (fault_set) begin
        irq_stat_reg[SSD_IRQ_MODE_FAULT_FLAG] <= 1'b1;
      end
      // Collision feeds no interrupt source; see R13
      o_irq <= ctrl_reg[SSD_CR_IRQ_EN] && |(irq_stat_reg & irq_mask_reg); // see R2
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= SSD_IDLE;
      shift_reg <= 8'h00;
      capt_reg <= 1'b0;
      dout_reg <= 1'b0;
      edge_cnt_reg <= 4'h0;
      sck_lvl_reg <= 1'b0;
      rx_buf_reg <= 8'h00;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= i_sck;
      if (wr_load) begin
        shift_reg <= i_wdata; // see R10
        edge_cnt_reg <= 4'h0;
        sck_lvl_reg <= 1'b0;
        if (!cpha) begin
          dout_reg <= i_wdata[7];
        end
        if (start) begin
          state_reg <= SSD_SHIFT;
        end
      end else if (fault_set && state_reg == SSD_SHIFT) begin
        state_reg <= SSD_IDLE;
        sck_lvl_reg <= 1'b0;
        edge_cnt_reg <= 4'h0;
      end else if (!busy) begin
        edge_cnt_reg <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
        sck_lvl_reg <= !sck_lvl_reg;
        if (!cpha && lead) begin
          capt_reg <= sample_in;
        end else if (!cpha) begin
          shift_reg <= {shift_reg[6:0], capt_reg};
          dout_reg <= shift_reg[6];
        end else if (lead) begin
          dout_reg <= shift_reg[7];
        end else begin
          shift_reg <= {shift_reg[6:0], sample_in};
        end
        if (last_edge) begin
          state_reg <= SSD_IDLE;
          rx_buf_reg <= cpha ? {shift_reg[6:0], sample_in}
                             : {shift_reg[6:0], capt_reg}; // see R9
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
      o_mosi <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_sck <= cpol ^ sck_lvl_reg;
      o_sck_oe <= ctrl_reg[SSD_CR_OUT_EN] && master;
      o_mosi <= dout_reg;
      o_mosi_oe <= ctrl_reg[SSD_CR_OUT_EN] && master;
      o_miso <= dout_reg;
      o_miso_oe <= slave_sel;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        SSD_OFF_DATA: o_rdata <= rx_buf_reg; // see R9
        SSD_OFF_CTRL: o_rdata <= ctrl_reg;
        SSD_OFF_STAT: o_rdata <= {done_reg, write_collision_flag_reg, 1'b0, mode_fault_flag_reg, 4'h0}; // see R11
        SSD_OFF_IRQ_STAT: o_rdata <= {6'h00, irq_stat_reg};
        SSD_OFF_IRQ_MASK: o_rdata <= {6'h00, irq_mask_reg};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== ssd_pkg.sv
// Constants for the serial status, data and baud-select block.
// Assumes a byte-wide register port and one system clock.
package ssd_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SSD_OFF_DATA = 8'h21;
  localparam logic [7:0] SSD_OFF_CTRL = 8'h22;
  localparam logic [7:0] SSD_OFF_STAT = 8'h23;
  localparam logic [7:0] SSD_OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] SSD_OFF_IRQ_MASK = 8'h25;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SSD_CR_IRQ_EN = 7;
  localparam int SSD_CR_OUT_EN = 6;
  localparam int SSD_CR_RATE_HI = 5;
  localparam int SSD_CR_MASTER = 4;
  localparam int SSD_CR_CPOL = 3;
  localparam int SSD_CR_CPHA = 2;
  localparam int SSD_CR_RATE_MID = 1;
  localparam int SSD_CR_RATE_LO = 0;
  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int SSD_SR_DONE = 7;
  localparam int SSD_SR_WRITE_COLLISION_FLAG = 6;
  localparam int SSD_SR_MODE_FAULT_FLAG = 4;
  localparam int SSD_IRQ_DONE = 0;
  localparam int SSD_IRQ_MODE_FAULT_FLAG = 1;
  localparam logic [7:0] SSD_CTRL_RST = 8'h00;
  localparam logic [7:0] SSD_STAT_RST = 8'h00;
  localparam logic [1:0] SSD_IRQ_RST = 2'h0;
  // ----------------------------------------------------------------
  // Rate codes {hi, mid, lo} and full-period divide ratios in clocks
  // ----------------------------------------------------------------
  localparam logic [2:0] SSD_RATE_DIV4 = 3'h4;
  localparam logic [2:0] SSD_RATE_DIV8 = 3'h0;
  localparam logic [2:0] SSD_RATE_DIV16 = 3'h1;
  localparam logic [2:0] SSD_RATE_DIV32 = 3'h6;
  localparam logic [2:0] SSD_RATE_DIV64 = 3'h2;
  localparam logic [2:0] SSD_RATE_DIV128 = 3'h3;
  localparam int SSD_DIV4 = 4;
  localparam int SSD_DIV8 = 8;
  localparam int SSD_DIV16 = 16;
  localparam int SSD_DIV32 = 32;
  localparam int SSD_DIV64 = 64;
  localparam int SSD_DIV128 = 128;
  localparam int SSD_HALF_W = 6;
  // Index of the last clock edge in a byte (16 edges per byte)
  localparam logic [3:0] SSD_LAST_EDGE = 4'hf;
  typedef enum logic [0:0] {
    SSD_IDLE = 1'b0,
    SSD_SHIFT = 1'b1
  } ssd_state_t;
endpackage

// ===== ssd_rate_gen.sv
// Serial clock edge generator for master mode.
// Assumes i_run drops between bytes so every byte starts on a fresh count.
`timescale 1ns/10ps
`default_nettype none
module ssd_rate_gen
  import ssd_pkg::*;
#(
  parameter int HALF_W = SSD_HALF_W
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [2:0] i_code,
  output logic o_tick
);
  if (HALF_W < SSD_HALF_W) begin : g_half_w_check
    $error("ssd_rate_gen: HALF_W too small for the slowest rate");
  end

  logic [HALF_W-1:0] half_last;
  logic [HALF_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Half period minus one per rate code
  // ----------------------------------------------------------------
  always_comb begin
    unique case (i_code)
      SSD_RATE_DIV4: half_last = HALF_W'(SSD_DIV4 / 2 - 1); // see R1
      SSD_RATE_DIV8: half_last = HALF_W'(SSD_DIV8 / 2 - 1);
      SSD_RATE_DIV16: half_last = HALF_W'(SSD_DIV16 / 2 - 1);
      SSD_RATE_DIV32: half_last = HALF_W'(SSD_DIV32 / 2 - 1);
      SSD_RATE_DIV64: half_last = HALF_W'(SSD_DIV64 / 2 - 1);
      SSD_RATE_DIV128: half_last = HALF_W'(SSD_DIV128 / 2 - 1);
      default: half_last = HALF_W'(SSD_DIV128 / 2 - 1);
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_run || cnt_reg >= half_last) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + HALF_W'(1);
    end
  end

  assign o_tick = i_run && (cnt_reg >= half_last);
endmodule
`default_nettype wire

// ===== ssd_monitor.sv
// Port assertions for the serial status, data and rate block.
// Assumes ssd_pkg and ssd_top are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module ssd_monitor
  import ssd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic i_ss_n,
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_miso_oe,
  input wire logic o_mosi_oe
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_stat_unused: assert property ($past(i_rd) && $past(i_addr) == SSD_OFF_STAT
    |-> o_rdata[5] == 1'b0 && o_rdata[3:0] == 4'h0)
    else $error("unused status bits read nonzero");
  chk_fault_drop: assert property (o_sck_oe && !i_ss_n |-> ##[1:4] !o_sck_oe)
    else $error("outputs still enabled after mode fault");
  chk_oe_pair: assert property (o_sck_oe == o_mosi_oe)
    else $error("clock and data enables disagree");
  chk_oe_exclusive: assert property (o_miso_oe |-> !o_mosi_oe)
    else $error("master and slave outputs both enabled");
  chk_irq_gate: assert property (i_wr && i_addr == SSD_OFF_CTRL
    && !i_wdata[SSD_CR_IRQ_EN] |-> ##2 !o_irq)
    else $error("interrupt high with enable bit clear");
  chk_sck_rate: assert property (o_sck_oe && $changed(o_sck)
    |=> $stable(o_sck) || !o_sck_oe)
    else $error("serial clock half period below two clocks");
  chk_ctrl_oe: assert property ($past(i_rd) && $past(i_addr) == SSD_OFF_CTRL
    |-> (o_rdata[SSD_CR_OUT_EN] && o_rdata[SSD_CR_MASTER]) == o_sck_oe)
    else $error("control bits disagree with output enables");
endmodule
bind ssd_top ssd_monitor mon (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_irq, .i_ss_n, .o_sck, .o_sck_oe, .o_miso_oe, .o_mosi_oe);
`default_nettype wire

// ===== ssd_slave_model.sv
// Behavioural far-side slave: shifts a byte out and in, MSB first.
// Assumes clock polarity 0, phase 0 and a select driven by the bench.
`timescale 1ns/10ps
`default_nettype none
module ssd_slave_model (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_sel,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic sck_q;
  logic [7:0] sh;
  always_ff @(posedge i_clk_sys) begin
    sck_q <= i_sck;
    if (i_reset) begin
      sh <= 8'h00;
      o_rx <= 8'h00;
    end else if (!i_sel) begin
      sh <= i_tx;
    end else if (i_sck && !sck_q) begin
      // Take a bit, then show the next well before the master samples
      o_rx <= {o_rx[6:0], i_mosi};
      sh <= {sh[6:0], ~sh[7]};
    end
  end
  // Deselected line shows the inverse, not a held value
  assign o_miso = i_sel ? sh[7] : ~sh[7];
endmodule
`default_nettype wire

// ===== ssd_top_tb.sv
// Self-checking bench for ssd_top with a slave model on the serial side.
// Assumes the monitor is bound through its own file.
`timescale 1ns/10ps
`default_nettype none
module ssd_top_tb
  import ssd_pkg::*;
();
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ss_n = 1'b1;
  logic sel = 1'b0;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] o_rdata;
  logic [7:0] s_rx;
  logic o_irq, o_sck, o_sck_oe, o_miso, o_miso_oe, o_mosi, o_mosi_oe, miso;
  int err_total = 0;
  int cmp_count = 0;
  int n = 0;
  int cyc = 0;
  logic [2:0] codes [6] = '{SSD_RATE_DIV4, SSD_RATE_DIV8, SSD_RATE_DIV16,
    SSD_RATE_DIV32, SSD_RATE_DIV64, SSD_RATE_DIV128};
  int divs [6] = '{SSD_DIV4, SSD_DIV8, SSD_DIV16, SSD_DIV32, SSD_DIV64, SSD_DIV128};
  ssd_top uut (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
    .i_ss_n, .i_sck(1'b0), .o_sck, .o_sck_oe, .i_miso(miso), .o_miso, .o_miso_oe,
    .i_mosi(1'b0), .o_mosi, .o_mosi_oe);
  ssd_slave_model slv (.i_clk_sys, .i_reset, .i_sel(sel), .i_sck(o_sck),
    .i_mosi(o_mosi), .i_tx(s_tx), .o_miso(miso), .o_rx(s_rx));
  always #12.5 i_clk_sys = ~i_clk_sys;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check(o_rdata, exp);
  endtask
  task automatic start(input logic [7:0] d, input logic [7:0] s);
    @(posedge i_clk_sys);
    s_tx <= s;
    // Model reloads its byte only while deselected
    @(posedge i_clk_sys);
    sel <= 1'b1;
    wr(SSD_OFF_DATA, d);
  endtask
  task automatic wait_sck(input logic v);
    while (o_sck !== v) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask
  task automatic wait_irq;
    n = 0;
    while (o_irq !== 1'b1 && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rd(SSD_OFF_STAT, SSD_STAT_RST);
    rd(SSD_OFF_CTRL, SSD_CTRL_RST);
    wr(SSD_OFF_IRQ_MASK, 8'h03);
    for (int i = 0; i < 6; i++) begin
      logic [7:0] d;
      d = 8'h96 ^ 8'(i * 17);
      wr(SSD_OFF_CTRL, {2'b11, codes[i][2], 1'b1, 2'b00, codes[i][1:0]});
      start(d, ~d);
      wait_sck(1'b1);
      n = 0;
      wait_sck(1'b0);
      wait_sck(1'b1);
      check(n[7:0], divs[i][7:0]);
      wait_irq();
      check(o_irq, 8'h01);
      sel <= 1'b0;
      rd(SSD_OFF_STAT, 8'h80);
      rd(SSD_OFF_DATA, ~d);
      rd(SSD_OFF_STAT, 8'h00);
      check(s_rx, d);
      wr(SSD_OFF_IRQ_STAT, 8'h01);
      repeat (2) @(negedge i_clk_sys);
      check(o_irq, 8'h00);
    end
    wr(SSD_OFF_CTRL, 8'hf0);
    start(8'h3c, 8'hc3);
    repeat (4) @(posedge i_clk_sys);
    wr(SSD_OFF_DATA, 8'h00);
    rd(SSD_OFF_STAT, 8'h40);
    check(o_irq, 8'h00);
    wait_irq();
    rd(SSD_OFF_STAT, 8'hc0);
    wr(SSD_OFF_DATA, 8'hff);
    repeat (40) @(posedge i_clk_sys);
    rd(SSD_OFF_STAT, 8'h40);
    rd(SSD_OFF_DATA, 8'hc3);
    rd(SSD_OFF_STAT, 8'h00);
    check(s_rx, 8'h3c);
    sel <= 1'b0;
    wr(SSD_OFF_IRQ_STAT, 8'h01);
    wr(SSD_OFF_CTRL, 8'hd0);
    i_ss_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_ss_n <= 1'b1;
    wait_irq();
    check(o_irq, 8'h01);
    rd(SSD_OFF_STAT, 8'h10);
    rd(SSD_OFF_CTRL, 8'h80);
    wr(SSD_OFF_CTRL, 8'h50);
    rd(SSD_OFF_STAT, 8'h00);
    rd(SSD_OFF_CTRL, 8'h50);
    wr(SSD_OFF_IRQ_STAT, 8'h02);
    rd(8'h30, 8'h00);
    wr(SSD_OFF_STAT, 8'hff);
    rd(SSD_OFF_STAT, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
